// ### pkg/apcfg_pkg.sv
// Package for the analog pin configuration block: offsets, resets, carriers
package apcfg_pkg;

  // ----------------------------------------
  // Register map (word index on plain port)
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_FIRST_LOWER = 4'h0;
  localparam logic [3:0] OFF_FIRST_UPPER = 4'h1;
  localparam logic [3:0] OFF_SECOND_LOWER = 4'h2;
  localparam logic [3:0] OFF_MODULE_DISABLE = 4'h3;
  localparam logic [3:0] OFF_PIN_STATUS_LO = 4'h4;
  localparam logic [3:0] OFF_PIN_STATUS_HI = 4'h5;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] RST_SELECT = 16'h0000;
  localparam logic [1:0] RST_DISABLE = 2'h0;
  localparam int BIT_FIRST_DISABLE = 0;
  localparam int BIT_SECOND_DISABLE = 1;
  localparam int CHANNELS = 32;
  localparam int LOW_CHANNELS = 16;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } apcfg_bus_req_s;

  typedef struct packed {
    logic [31:0] digital;
    logic [31:0] readEnable;
    logic [31:0] firstMuxGround;
    logic [15:0] secondMuxGround;
  } apcfg_pin_ctl_s;

endpackage : apcfg_pkg

// ### tb/apcfg_checker.sv
// Port assertions for the analog pin selector
`timescale 1ns/1ns
module apcfg_checker import apcfg_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Watched ports
  input wire apcfg_pkg::apcfg_bus_req_s busReq,
  input wire logic [15:0] rdData,
  input wire apcfg_pkg::apcfg_pin_ctl_s pinCtl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rden; pinCtl.readEnable == pinCtl.digital; endproperty
  a_rden: assert property (p_rden) else $error("read enable differs");
  property p_gnd1; (pinCtl.digital & ~pinCtl.firstMuxGround) == '0; endproperty
  a_gnd1: assert property (p_gnd1) else $error("digital pin sampled");
  property p_gnd2; (pinCtl.digital[15:0] & ~pinCtl.secondMuxGround) == '0; endproperty
  a_gnd2: assert property (p_gnd2) else $error("second mux not grounded");
  property p_upper; pinCtl.digital[31:16] == pinCtl.firstMuxGround[31:16]; endproperty
  a_upper: assert property (p_upper) else $error("upper ground mismatch");
  property p_rst; $fell(srst) |-> pinCtl == '0; endproperty
  a_rst: assert property (p_rst) else $error("pins not analog at reset");
  property p_unmap; (busReq.rd && busReq.addr > OFF_PIN_STATUS_HI) |=> rdData == '0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_rw; (busReq.wr && busReq.addr == OFF_FIRST_UPPER) ##1 (busReq.rd && busReq.addr == OFF_FIRST_UPPER)
    |=> rdData == $past(busReq.wdata, 2); endproperty
  a_rw: assert property (p_rw) else $error("readback differs");
  property p_cause; $changed(pinCtl) |-> |{$past(busReq.wr, 2), $past(srst), $past(srst, 2), $past(srst, 3)};
  endproperty
  a_cause: assert property (p_cause) else $error("pins moved without write");
  c_wr: cover property (busReq.wr ##1 busReq.rd);
  c_dig: cover property (pinCtl.digital == '1);
  c_mix: cover property (pinCtl.digital != pinCtl.firstMuxGround);
endmodule : apcfg_checker
bind apcfg_top apcfg_checker u_apcfg_checker (.sys_clk(sys_clk), .srst(srst), .busReq(busReq), .rdData(rdData),
  .pinCtl(pinCtl));

// ### tb/apcfg_pin_model.sv
// Port pin view of the selector controls
`timescale 1ns/1ns
module apcfg_pin_model import apcfg_pkg::*; (
  // Controls from the selector
  input wire apcfg_pkg::apcfg_pin_ctl_s pinCtl,
  // Port read input as software sees it
  output logic [31:0] portRead
);
  // Pins held at a fixed pattern; a disabled read input reads zero
  assign portRead = pinCtl.readEnable & 32'hC3C3C3C3;
endmodule : apcfg_pin_model

// ### tb/testbench.sv
// Self-checking bench for the analog pin selector
`timescale 1ns/1ns
module testbench;
  import apcfg_pkg::*;
  logic sys_clk;
  logic srst;
  apcfg_bus_req_s busReq;
  logic [15:0] rdData;
  apcfg_pin_ctl_s pinCtl;
  logic [31:0] portRead;
  int num_errors = 0;
  int tests_run = 0;
  // Channel 31 has no input, so its bit must do nothing
  apcfg_top #(.FIRST_PRESENT(32'h7FFFFFFF)) u_apcfg_top (.sys_clk(sys_clk), .srst(srst), .busReq(busReq),
    .rdData(rdData), .pinCtl(pinCtl));
  apcfg_pin_model u_apcfg_pin_model (.pinCtl(pinCtl), .portRead(portRead));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [111:0] exp, input logic [111:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1 check("rdData", 112'(exp), 112'(rdData));
  endtask : rd
  task automatic pins(input logic [31:0] dig, input logic [31:0] g1, input logic [15:0] g2);
    busReq.wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 check("pinCtl", {dig, dig, g1, g2}, pinCtl);
    check("portRead", 112'(dig & 32'hC3C3C3C3), 112'(portRead));
  endtask : pins
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    busReq = '0;
    srst = 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    pins(32'h80000000, 32'h80000000, 16'h0000);
    for (int i = 0; i < 4; i++) rd(4'(i), 16'h0000);
    wr(OFF_FIRST_LOWER, 16'h00FF);
    wr(OFF_FIRST_UPPER, 16'h5A5A);
    wr(OFF_SECOND_LOWER, 16'hFFFF);
    pins(32'hDA5A00FF, 32'hDA5A00FF, 16'hFFFF);
    wr(OFF_SECOND_LOWER, 16'h0F0F);
    pins(32'hDA5A000F, 32'hDA5A00FF, 16'h0F0F);
    wr(OFF_MODULE_DISABLE, 16'h0001);
    pins(32'hFFFF0F0F, 32'hFFFFFFFF, 16'h0F0F);
    wr(OFF_MODULE_DISABLE, 16'h0003);
    pins(32'hFFFFFFFF, 32'hFFFFFFFF, 16'hFFFF);
    wr(OFF_PIN_STATUS_LO, 16'h1234);
    wr(4'hF, 16'hFFFF);
    wr(OFF_FIRST_UPPER, 16'hFFFF);
    rd(OFF_FIRST_UPPER, 16'hFFFF);
    rd(OFF_PIN_STATUS_LO, 16'hFFFF);
    rd(4'hF, 16'h0000);
    // Mid-run reset: selectors and disables return to their reset values
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    pins(32'h80000000, 32'h80000000, 16'h0000);
    rd(OFF_FIRST_UPPER, 16'h0000);
    rd(OFF_MODULE_DISABLE, 16'h0000);
    conclude();
  end
  // Whole run is under a hundred cycles
  initial begin
    #20000;
    num_errors++;
    conclude();
  end
endmodule : testbench

// ### verilog/apcfg_regfile.sv
// Small register store for the selector words, read data registered
`timescale 1ns/1ns
module apcfg_regfile #(
  parameter int WORDS = 4,
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Write side
  input wire logic wrEn,
  input wire logic [$clog2(WORDS)-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  // Read side
  input wire logic [$clog2(WORDS)-1:0] rdIdx,
  output logic [WIDTH-1:0] rdData,
  // All words, for the pin logic
  output logic [WORDS*WIDTH-1:0] allWords
);
  import apcfg_pkg::*;

  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } apcfg_rf_state_s;

  apcfg_rf_state_s st_r;
  apcfg_rf_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd = st_r.mem[rdIdx];
    if (wrEn) begin
      st_nxt.mem[wrIdx] = wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rd;
  assign allWords = st_r.mem;

endmodule : apcfg_regfile

// ### verilog/apcfg_top.sv
// Analog/digital pin selector for two converters sharing port pins
// ----------------------------------------
// ----------------------------------------
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module apcfg_top #(
  parameter logic [31:0] FIRST_PRESENT = 32'hFFFFFFFF,
  parameter logic [15:0] SECOND_PRESENT = 16'hFFFF,
  parameter bit HAS_SECOND = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire apcfg_pkg::apcfg_bus_req_s busReq,
  output logic [15:0] rdData,
  // Pin and multiplexer controls
  output apcfg_pkg::apcfg_pin_ctl_s pinCtl
);
  import apcfg_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] moduleDisable;
    apcfg_pin_ctl_s pins;
    logic [15:0] localRd;
    logic useLocal;
  } apcfg_state_s;

  apcfg_state_s st_r;
  apcfg_state_s st_nxt;

  logic [15:0] storeRd;
  logic [63:0] words;
  logic storeWr;
  logic [1:0] storeIdx;

  // Selector words live in the store: first lower, first upper, second lower
  function automatic logic is_store(input logic [3:0] a);
    return (a == OFF_FIRST_LOWER) || (a == OFF_FIRST_UPPER) || (a == OFF_SECOND_LOWER);
  endfunction : is_store

  assign storeWr = busReq.wr && is_store(busReq.addr);
  assign storeIdx = busReq.addr[1:0];

  apcfg_regfile #(
    .WORDS(4),
    .WIDTH(16)
  ) u_store (
    .sys_clk(sys_clk),
    .srst(srst),
    .wrEn(storeWr),
    .wrIdx(storeIdx),
    .wrData(busReq.wdata),
    .rdIdx(storeIdx),
    .rdData(storeRd),
    .allWords(words)
  );

  // ----------------------------------------
  // Pin decision
  // ----------------------------------------
  logic [31:0] firstSel;
  logic [15:0] secondSel;
  logic [31:0] analogFirst;
  logic [15:0] analogSecond;
  logic [31:0] analogAny;

  always_comb begin
    firstSel = {words[31:16], words[15:0]};
    secondSel = words[47:32];
    // Analog only where an input exists and module is on
    analogFirst = ~firstSel & FIRST_PRESENT;
    if (st_r.moduleDisable[BIT_FIRST_DISABLE]) begin
      analogFirst = '0;
    end
    analogSecond = ~secondSel & SECOND_PRESENT;
    if (!HAS_SECOND || st_r.moduleDisable[BIT_SECOND_DISABLE]) begin
      analogSecond = '0;
    end
    // Either converter claiming a shared pin makes it analog
    analogAny = analogFirst | {16'h0000, analogSecond};
  end

  // ----------------------------------------
  // Bus and output registers
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.useLocal = 1'b1;
    st_nxt.localRd = 16'h0000;
    if (busReq.wr && busReq.addr == OFF_MODULE_DISABLE) begin
      st_nxt.moduleDisable = busReq.wdata[1:0];
    end
    if (busReq.rd) begin
      if (is_store(busReq.addr)) begin
        st_nxt.useLocal = 1'b0;
      end else if (busReq.addr == OFF_MODULE_DISABLE) begin
        st_nxt.localRd = {14'h0000, st_r.moduleDisable};
      end else if (busReq.addr == OFF_PIN_STATUS_LO) begin
        st_nxt.localRd = st_r.pins.digital[15:0];
      end else if (busReq.addr == OFF_PIN_STATUS_HI) begin
        st_nxt.localRd = st_r.pins.digital[31:16];
      end
    end
    st_nxt.pins.digital = ~analogAny;
    st_nxt.pins.readEnable = ~analogAny;
    st_nxt.pins.firstMuxGround = ~analogFirst;
    st_nxt.pins.secondMuxGround = ~analogSecond;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r.moduleDisable <= RST_DISABLE;
      st_r.pins <= '{32'h00000000, 32'h00000000, 32'h00000000, 16'h0000};
      st_r.localRd <= 16'h0000;
      st_r.useLocal <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.useLocal ? st_r.localRd : storeRd;
  assign pinCtl = st_r.pins;

endmodule : apcfg_top
